// ---- tlga_pkg.sv ----
package tlga_pkg;

   // ==========================================================
   // Object numbering of the disabling gates
   localparam int DG_NUM = 4;
   localparam int DG_IN_OBJ_BASE = 94;
   localparam int DG_OUT_OBJ_BASE = 95;
   localparam int DG_DIS_OBJ_BASE = 96;
   localparam int DG_OBJ_STEP = 3;
   localparam int DG_VAL_W = 16;

   // ==========================================================
   // Logic gate sizing
   localparam int LG_NUM = 16;
   localparam int LG_IN_NUM = 4;
   localparam int LG_CNT_W = 5;

   // ==========================================================
   // Value widths, operations, delay modes
   typedef enum logic [1:0] {
      TLGA_W_BIT = 2'b00,
      TLGA_W_BYTE = 2'b01,
      TLGA_W_WORD = 2'b10
   } tlga_width_e;

   typedef enum logic [1:0] {
      TLGA_OP_AND = 2'b00,
      TLGA_OP_OR = 2'b01,
      TLGA_OP_XOR = 2'b10,
      TLGA_OP_ANDFB = 2'b11
   } tlga_op_e;

   typedef enum logic [1:0] {
      TLGA_DLY_SUPPRESS = 2'b00,
      TLGA_DLY_TIMED = 2'b01,
      TLGA_DLY_NONE = 2'b10
   } tlga_dly_e;

   localparam logic [DG_VAL_W-1:0] DG_MASK_BIT = 16'h0001;
   localparam logic [DG_VAL_W-1:0] DG_MASK_BYTE = 16'h00ff;
   localparam logic [DG_VAL_W-1:0] DG_MASK_WORD = 16'hffff;

   // ==========================================================
   // Timing: delays and cycle times count in 100 ms ticks
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
   localparam int DELAY_MAX_MIN = 100;
   localparam int DELAY_MAX_TICKS = DELAY_MAX_MIN * 60 * 1000 / TICK_MS;
   localparam int TIMER_W = 16;
   localparam int TICK_CNT_W = 32;

endpackage

// ---- tlga_top.sv ----
module tlga_top
   import tlga_pkg::*;
#(
   parameter int NUM_DG = DG_NUM,
   parameter int NUM_LG = LG_NUM,
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   // Disabling gate configuration
   input wire logic [NUM_DG-1:0][1:0] dg_width,
   input wire logic [NUM_DG-1:0] dg_block_on_one,
   input wire logic [NUM_DG-1:0] dg_init_blocked,
   input wire logic [NUM_DG-1:0] dg_src_int,
   // Disabling gate objects
   input wire logic [NUM_DG-1:0] dg_in_wr,
   input wire logic [NUM_DG-1:0][DG_VAL_W-1:0] dg_in_val,
   input wire logic [NUM_DG-1:0] dg_int_wr,
   input wire logic [NUM_DG-1:0][DG_VAL_W-1:0] dg_int_val,
   input wire logic [NUM_DG-1:0] dg_dis_wr,
   input wire logic [NUM_DG-1:0] dg_dis_val,
   output logic [NUM_DG-1:0] dg_out_req,
   output logic [NUM_DG-1:0][DG_VAL_W-1:0] dg_out_val,
   input wire logic [NUM_DG-1:0] dg_out_ack,
   output logic [NUM_DG-1:0] dg_blocked,
   // Logic gate configuration
   input wire logic [LG_CNT_W-1:0] lg_count,
   input wire logic [NUM_LG-1:0][1:0] lg_op,
   input wire logic [NUM_LG-1:0][1:0] lg_n_in,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_in_inv,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_in_int,
   input wire logic [NUM_LG-1:0] lg_out_inv,
   input wire logic [NUM_LG-1:0] lg_send_change,
   input wire logic [NUM_LG-1:0][1:0] lg_on_mode,
   input wire logic [NUM_LG-1:0][TIMER_W-1:0] lg_on_delay,
   input wire logic [NUM_LG-1:0][1:0] lg_off_mode,
   input wire logic [NUM_LG-1:0][TIMER_W-1:0] lg_off_delay,
   input wire logic [NUM_LG-1:0] lg_cyc_en,
   input wire logic [NUM_LG-1:0][TIMER_W-1:0] lg_cyc_period,
   // Logic gate objects
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_in_wr,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_in_val,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_int_wr,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_int_val,
   output logic [NUM_LG-1:0] lg_out_req,
   output logic [NUM_LG-1:0] lg_out_val,
   input wire logic [NUM_LG-1:0] lg_out_ack
);

   // ==========================================================
   // Initialisation and 100 ms tick
   logic init_done;
   logic [TICK_CNT_W-1:0] tick_cnt;
   logic tick;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_done <= 1'b0;
      end else begin
         init_done <= 1'b1;
      end
   end

   assign tick = (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   // ==========================================================
   // Disabling gates
   genvar g;
   generate
      for (g = 0; g < NUM_DG; g++) begin : g_dg
         logic blocked;
         logic pending;
         logic [DG_VAL_W-1:0] latest;
         logic use_int;
         logic wr;
         logic [DG_VAL_W-1:0] val;
         logic next_blocked;
         logic send;

         always_comb begin
            use_int = dg_src_int[g] && (dg_width[g] != TLGA_W_BYTE);
            wr = init_done && (use_int ? dg_int_wr[g] : dg_in_wr[g]);
            unique case (dg_width[g])
               TLGA_W_BIT: val = DG_MASK_BIT;
               TLGA_W_BYTE: val = DG_MASK_BYTE;
               default: val = DG_MASK_WORD;
            endcase
            val = val & (use_int ? dg_int_val[g] : dg_in_val[g]);
            next_blocked = blocked;
            if (init_done && dg_dis_wr[g]) begin
               next_blocked = (dg_dis_val[g] == dg_block_on_one[g]);
            end
            // Release with a value held back sends it at once
            send = (wr && !next_blocked)
               || (blocked && !next_blocked && pending);
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               blocked <= 1'b0;
            end else if (!init_done) begin
               blocked <= dg_init_blocked[g];
            end else begin
               blocked <= next_blocked;
            end
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               latest <= '0;
               pending <= 1'b0;
            end else begin
               if (wr) begin
                  latest <= val;
               end
               if (wr && next_blocked) begin
                  pending <= 1'b1;
               end else if (send) begin
                  pending <= 1'b0;
               end
            end
         end

         // New send while one waits replaces its value
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               dg_out_req[g] <= 1'b0;
               dg_out_val[g] <= '0;
            end else if (send) begin
               dg_out_req[g] <= 1'b1;
               dg_out_val[g] <= wr ? val : latest;
            end else if (dg_out_ack[g]) begin
               dg_out_req[g] <= 1'b0;
            end
         end

         assign dg_blocked[g] = blocked;
      end
   endgenerate

   // ==========================================================
   // Logic gates
   genvar i;
   generate
      for (i = 0; i < NUM_LG; i++) begin : g_lg
         logic [LG_IN_NUM-1:0] st;
         logic [LG_IN_NUM-1:0] next_st;
         logic [LG_IN_NUM-1:0] mask;
         logic [LG_IN_NUM-1:0] wr;
         logic [LG_IN_NUM-1:0] val;
         logic gate_en;
         logic ev;
         logic res;
         logic [1:0] mode;
         logic [TIMER_W-1:0] dly;
         logic pend;
         logic pend_val;
         logic [TIMER_W-1:0] pend_cnt;
         logic expire;
         logic commit;
         logic commit_val;
         logic out_st;
         logic out_new;
         logic send_ok;
         logic [TIMER_W-1:0] cyc_cnt;
         logic cyc_fire;

         always_comb begin
            gate_en = init_done && (LG_CNT_W'(i) < lg_count);
            mask = 4'hf >> (2'h3 - lg_n_in[i]);
            for (int k = 0; k < LG_IN_NUM; k++) begin
               // Internal value, e.g. a limit flag, or external object
               wr[k] = gate_en && mask[k] && (lg_in_int[i][k] ?
                  lg_int_wr[i][k] : lg_in_wr[i][k]);
               val[k] = (lg_in_int[i][k] ? lg_int_val[i][k]
                  : lg_in_val[i][k]) ^ lg_in_inv[i][k];
            end
            next_st = st;
            for (int k = 0; k < LG_IN_NUM; k++) begin
               if (wr[k]) begin
                  next_st[k] = val[k];
               end
            end
            if (lg_op[i] == TLGA_OP_ANDFB
                && |(wr & ~val & mask & 4'he)) begin
               next_st[0] = 1'b0;
            end
            ev = |wr;
            unique case (lg_op[i])
               TLGA_OP_OR: res = |(next_st & mask);
               TLGA_OP_XOR: res = ^(next_st & mask);
               default: res = &(next_st | ~mask);
            endcase
            mode = res ? lg_on_mode[i] : lg_off_mode[i];
            dly = res ? lg_on_delay[i] : lg_off_delay[i];
            if (dly == '0) begin
               dly = TIMER_W'(1);
            end
            expire = pend && tick && (pend_cnt <= TIMER_W'(1));
            commit = ev ? (mode == TLGA_DLY_NONE) : expire;
            commit_val = ev ? res : pend_val;
            out_new = commit_val ^ lg_out_inv[i];
            send_ok = !lg_send_change[i] || (out_new != out_st);
            cyc_fire = gate_en && lg_cyc_en[i] && tick
               && (cyc_cnt + 1'b1 >= lg_cyc_period[i]);
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               st <= '0;
            end else if (ev) begin
               st <= next_st;
               if (commit && lg_op[i] == TLGA_OP_ANDFB) begin
                  st[0] <= res;
               end
            end else if (commit && lg_op[i] == TLGA_OP_ANDFB) begin
               st[0] <= commit_val;
            end
         end

         // Every telegram restarts the delay toward its new result in timed mode, and clears it in the other modes
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               pend <= 1'b0;
               pend_val <= 1'b0;
               pend_cnt <= '0;
            end else if (ev) begin
               pend <= (mode == TLGA_DLY_TIMED);
               pend_val <= res;
               pend_cnt <= dly;
            end else if (expire) begin
               pend <= 1'b0;
            end else if (pend && tick) begin
               pend_cnt <= pend_cnt - 1'b1;
            end
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               out_st <= 1'b0;
            end else if (commit) begin
               out_st <= out_new;
            end
         end

         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               cyc_cnt <= '0;
            end else if (!(gate_en && lg_cyc_en[i]) || cyc_fire) begin
               cyc_cnt <= '0;
            end else if (tick) begin
               cyc_cnt <= cyc_cnt + 1'b1;
            end
         end

         // Registered output: closing any loop through inputs is safe
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               lg_out_req[i] <= 1'b0;
               lg_out_val[i] <= 1'b0;
            end else if (commit && send_ok) begin
               lg_out_req[i] <= 1'b1;
               lg_out_val[i] <= out_new;
            end else if (cyc_fire) begin
               lg_out_req[i] <= 1'b1;
               lg_out_val[i] <= out_st;
            end else if (lg_out_ack[i]) begin
               lg_out_req[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

// ---- tlga_bus_node.sv ----
// ======
// Far-side bus nodes accepting send requests
module tlga_bus_node
   import tlga_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic [W-1:0] req,
   output logic [W-1:0] ack
);
   // Ack pulses, dropped at once so a follow-on send is never acked early
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= '0;
      end else if (stall) begin
         ack <= '0;
      end else begin
         ack <= req & ~ack;
      end
   end
endmodule

// ---- tlga_sva.sv ----
// ======
// Port checker
module tlga_sva
   import tlga_pkg::*;
#(
   parameter int NUM_DG = DG_NUM,
   parameter int NUM_LG = LG_NUM
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [NUM_DG-1:0][1:0] dg_width,
   input wire logic [NUM_DG-1:0] dg_block_on_one,
   input wire logic [NUM_DG-1:0] dg_init_blocked,
   input wire logic [NUM_DG-1:0] dg_src_int,
   input wire logic [NUM_DG-1:0] dg_in_wr,
   input wire logic [NUM_DG-1:0][DG_VAL_W-1:0] dg_in_val,
   input wire logic [NUM_DG-1:0] dg_dis_wr,
   input wire logic [NUM_DG-1:0] dg_dis_val,
   input wire logic [NUM_DG-1:0] dg_out_req,
   input wire logic [NUM_DG-1:0][DG_VAL_W-1:0] dg_out_val,
   input wire logic [NUM_DG-1:0] dg_out_ack,
   input wire logic [NUM_DG-1:0] dg_blocked,
   input wire logic [LG_CNT_W-1:0] lg_count,
   input wire logic [NUM_LG-1:0] lg_send_change,
   input wire logic [NUM_LG-1:0][1:0] lg_on_mode,
   input wire logic [NUM_LG-1:0][1:0] lg_off_mode,
   input wire logic [NUM_LG-1:0] lg_cyc_en,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_in_int,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_in_wr,
   input wire logic [NUM_LG-1:0][LG_IN_NUM-1:0] lg_int_wr,
   input wire logic [NUM_LG-1:0] lg_out_req,
   input wire logic [NUM_LG-1:0] lg_out_ack
);
   logic up;
   logic imm;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Inputs on the first edge after reset are ignored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         up <= 1'b0;
      end else begin
         up <= 1'b1;
      end
   end
   assign imm = lg_on_mode[0] == TLGA_DLY_NONE
      && lg_off_mode[0] == TLGA_DLY_NONE;
   property p_init;
      $rose(up) |-> dg_blocked == dg_init_blocked;
   endproperty
   a_init: assert property (p_init) else $error("init block");
   property p_fwd;
      up && dg_in_wr[0] && !dg_dis_wr[0] && !dg_blocked[0]
         && !dg_src_int[0] && dg_width[0] == TLGA_W_WORD
         |=> dg_out_req[0] && dg_out_val[0] == $past(dg_in_val[0]);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward");
   property p_byte;
      $rose(dg_out_req[0]) && $past(dg_width[0]) == TLGA_W_BYTE
         |-> dg_out_val[0][15:8] == 8'h00;
   endproperty
   a_byte: assert property (p_byte) else $error("byte mask");
   property p_pol;
      up && dg_dis_wr[0] |=> dg_blocked[0]
         == ($past(dg_dis_val[0]) == $past(dg_block_on_one[0]));
   endproperty
   a_pol: assert property (p_pol) else $error("polarity");
   property p_blk_stable;
      up && !dg_dis_wr[0] |=> $stable(dg_blocked[0]);
   endproperty
   a_blk_stable: assert property (p_blk_stable) else $error("blk");
   property p_blk_quiet;
      up && dg_blocked[0] && !dg_out_req[0] && !dg_dis_wr[0]
         |=> !dg_out_req[0];
   endproperty
   a_blk_quiet: assert property (p_blk_quiet) else $error("quiet");
   property p_dg_hold;
      dg_out_req[0] && !dg_out_ack[0] |=> dg_out_req[0];
   endproperty
   a_dg_hold: assert property (p_dg_hold) else $error("dg hold");
   property p_lg_hold;
      lg_out_req[0] && !lg_out_ack[0] |=> lg_out_req[0];
   endproperty
   a_lg_hold: assert property (p_lg_hold) else $error("lg hold");
   property p_lg_imm;
      up && lg_in_wr[0][0] && !lg_in_int[0][0] && lg_count != 5'h00
         && imm && !lg_send_change[0] |=> lg_out_req[0];
   endproperty
   a_lg_imm: assert property (p_lg_imm) else $error("lg send");
   property p_lg_quiet;
      up && lg_in_wr[0] == 4'h0 && lg_int_wr[0] == 4'h0 && imm
         && !lg_cyc_en[0] && !lg_out_req[0] |=> !lg_out_req[0];
   endproperty
   a_lg_quiet: assert property (p_lg_quiet) else $error("lg idle");
   c_release: cover property (dg_blocked[0] ##1 !dg_blocked[0]);
   c_stall: cover property (dg_out_req[0] [*5]);
   c_lg: cover property (lg_out_req[0] && lg_cyc_en[0]);
endmodule
bind tlga_top tlga_sva #(.NUM_DG(NUM_DG), .NUM_LG(NUM_LG)) tlga_sva_i (.*);

// ---- tb_top.sv ----
module tb_top
   import tlga_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, stall, ia, ib;
   logic [3:0][1:0] dg_width;
   logic [3:0] dg_block_on_one, dg_init_blocked, dg_src_int, dg_in_wr;
   logic [3:0] dg_int_wr, dg_dis_wr, dg_dis_val, dg_out_req, dg_out_ack;
   logic [3:0] dg_blocked;
   logic [3:0][15:0] dg_in_val, dg_int_val, dg_out_val;
   logic [4:0] lg_count;
   logic [15:0][1:0] lg_op, lg_n_in, lg_on_mode, lg_off_mode;
   logic [15:0][3:0] lg_in_inv, lg_in_int, lg_in_wr, lg_in_val;
   logic [15:0][3:0] lg_int_wr, lg_int_val;
   logic [15:0] lg_out_inv, lg_send_change, lg_cyc_en, lg_out_req;
   logic [15:0] lg_out_val, lg_out_ack;
   logic [15:0][15:0] lg_on_delay, lg_off_delay, lg_cyc_period;
   int n_fail, tests_run;
   bit got;
   // Ten cycles per tick keeps timed cases short
   tlga_top #(.TICK_CYCLES(10)) tlga_top_i (.*);
   tlga_bus_node #(.W(4)) tlga_bus_node_i (.ref_clk(ref_clk),
      .rst_n(rst_n), .stall(stall), .req(dg_out_req), .ack(dg_out_ack));
   tlga_bus_node #(.W(16)) tlga_bus_node_lg (.ref_clk(ref_clk),
      .rst_n(rst_n), .stall(stall), .req(lg_out_req), .ack(lg_out_ack));
   // ======
   // Shared tasks
   task chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task wreq(input int n, input bit lg);
      got = 0;
      for (int i = 0; i < n && !got; i++) begin
         #1;
         got = lg ? lg_out_req[0] === 1'b1 : dg_out_req[0] === 1'b1;
         if (!got) @(posedge ref_clk);
      end
   endtask
   task dgs(input bit i, input logic [15:0] v, input bit s,
      input logic [15:0] ev);
      @(posedge ref_clk);
      dg_int_wr[0] <= i;
      dg_in_wr[0] <= !i;
      dg_in_val[0] <= v;
      dg_int_val[0] <= v;
      @(posedge ref_clk);
      dg_in_wr[0] <= 0;
      dg_int_wr[0] <= 0;
      wreq(4, 0);
      chk(got == s && (!s || dg_out_val[0] === ev), "gate out");
      if (s) repeat (3) @(posedge ref_clk);
   endtask
   task dis(input bit v);
      @(posedge ref_clk);
      dg_dis_wr[0] <= 1;
      dg_dis_val[0] <= v;
      @(posedge ref_clk);
      dg_dis_wr[0] <= 0;
      #1;
   endtask
   task lgs(input int k, input bit v, i, s, ev, input int n);
      @(posedge ref_clk);
      lg_int_wr[0][k] <= i;
      lg_in_wr[0][k] <= !i;
      lg_in_val[0][k] <= v;
      lg_int_val[0][k] <= v;
      @(posedge ref_clk);
      lg_in_wr[0] <= 4'h0;
      lg_int_wr[0] <= 4'h0;
      wreq(n, 1);
      chk(got == s && (!s || lg_out_val[0] === ev), "logic out");
      if (s) repeat (3) @(posedge ref_clk);
   endtask
   function logic f(int op, logic a, logic b);
      logic r;
      r = op == 0 ? a & b : op == 1 ? a | b : a ^ b;
      return r ^ (op == 2);
   endfunction
   task wrap_up;
      $display("checks %0d errors %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ======
   // Scenarios
   task t_dg;
      chk(dg_blocked === 4'ha, "init");
      dg_width[0] <= TLGA_W_WORD;
      dgs(0, 16'h1234, 1, 16'h1234);
      dg_width[0] <= TLGA_W_BIT;
      dgs(0, 16'hffff, 1, 16'h0001);
      dg_width[0] <= TLGA_W_BYTE;
      dg_src_int[0] <= 1;
      dgs(1, 16'h5555, 0, 16'h0000);
      dgs(0, 16'h12ab, 1, 16'h00ab);
      dg_width[0] <= TLGA_W_WORD;
      dgs(0, 16'h4444, 0, 16'h0000);
      dgs(1, 16'hbeef, 1, 16'hbeef);
      dg_src_int[0] <= 0;
      dis(1);
      chk(dg_blocked[0] === 1'b1, "block");
      dgs(0, 16'h0005, 0, 16'h0000);
      dgs(0, 16'h0006, 0, 16'h0000);
      dis(0);
      wreq(4, 0);
      chk(got && dg_out_val[0] === 16'h0006, "release");
      repeat (3) @(posedge ref_clk);
      stall <= 1;
      dgs(0, 16'h0077, 1, 16'h0077);
      chk(dg_out_req[0] === 1'b1, "held");
      stall <= 0;
      repeat (4) @(posedge ref_clk);
      #1;
      chk(dg_out_req[0] === 1'b0, "accepted");
   endtask
   task t_lg;
      lgs(0, 1, 0, 0, 0, 4);
      lg_count <= 5'h01;
      lg_n_in[0] <= 2'h0;
      lgs(1, 1, 0, 0, 0, 4);
      lg_n_in[0] <= 2'h1;
      for (int op = 0; op < 3; op++) begin
         lg_op[0] <= op[1:0];
         lg_out_inv[0] <= op == 2;
         for (int v = 0; v < 4; v++) begin
            lgs(1, v[1], 0, 1, f(op, ia, v[1]), 4);
            ib = v[1];
            lgs(0, v[0], 0, 1, f(op, v[0], ib), 4);
            ia = v[0];
         end
      end
      // Inverted input 1 seen as 0 against input 2 at 1
      lg_in_inv[0][0] <= 1;
      lgs(0, 1, 0, 1, f(2, 0, 1), 4);
      lg_in_inv[0][0] <= 0;
      lg_op[0] <= TLGA_OP_ANDFB;
      lg_out_inv[0] <= 0;
      lgs(1, 0, 0, 1, 0, 4);
      lgs(0, 1, 0, 1, 0, 4);
      lgs(1, 1, 0, 1, 0, 4);
      lgs(0, 1, 0, 1, 1, 4);
      lgs(1, 0, 0, 1, 0, 4);
      lgs(1, 1, 0, 1, 0, 4);
      lg_op[0] <= TLGA_OP_OR;
      lg_n_in[0] <= 2'h0;
      lg_on_mode[0] <= TLGA_DLY_TIMED;
      lg_on_delay[0] <= 16'h0003;
      lgs(0, 1, 0, 0, 0, 15);
      lgs(0, 1, 0, 0, 0, 20);
      wreq(12, 1);
      chk(got && lg_out_val[0] === 1'b1, "delayed");
      repeat (3) @(posedge ref_clk);
      lg_on_mode[0] <= TLGA_DLY_SUPPRESS;
      lgs(0, 0, 0, 1, 0, 4);
      lgs(0, 1, 0, 0, 0, 8);
      lg_on_mode[0] <= TLGA_DLY_NONE;
      lg_send_change[0] <= 1;
      lgs(0, 1, 0, 1, 1, 4);
      lgs(0, 1, 0, 0, 0, 4);
      lg_in_int[0][0] <= 1;
      lgs(0, 0, 0, 0, 0, 4);
      lgs(0, 0, 1, 1, 0, 4);
      lg_in_int[0][0] <= 0;
      lg_send_change[0] <= 0;
      lg_cyc_period[0] <= 16'h0004;
      lg_cyc_en[0] <= 1;
      wreq(85, 1);
      chk(got && lg_out_val[0] === 1'b0, "cyclic");
      lg_cyc_en[0] <= 0;
      // Gates never written or enabled must stay silent
      chk(lg_out_req[15:1] === 15'h0000, "idle logic gates");
      chk(dg_out_req[3:1] === 3'h0, "idle disabling gates");
   endtask
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_fail++;
      wrap_up;
   end
   initial begin
      {rst_n, stall, ia, ib, dg_width, dg_src_int, dg_in_wr, dg_in_val,
         dg_int_wr, dg_int_val, dg_dis_wr, dg_dis_val, lg_count, lg_op,
         lg_in_inv, lg_in_int, lg_in_wr, lg_in_val, lg_int_wr, lg_int_val,
         lg_out_inv, lg_send_change, lg_on_delay, lg_off_delay,
         lg_cyc_en, lg_cyc_period} = '0;
      dg_init_blocked = 4'ha;
      dg_block_on_one = 4'h1;
      lg_on_mode = {16{2'h2}};
      lg_off_mode = {16{2'h2}};
      lg_n_in = 32'h0000_0000;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1;
      repeat (3) @(posedge ref_clk);
      #1;
      t_dg;
      t_lg;
      wrap_up;
   end
endmodule
